// *** core/pin_ctrl_pkg.sv ***
// Constants for the control pin logic: register map, fields, timing.
// Assumes a 20 MHz pclk and a zero-wait APB slave at 32-bit data.
// Operation
// - Standby requested when the pin level differs from the polarity invert bit.
// - Release processor reset at the configured power up slot.
// - Reset stays released in system-on; asserted at power down reset point.
// - Interrupt pin driven low while an unmasked latch is pending.
// - Latches clear only by writing one; interrupt pin then releases.
// - Test bit pulses interrupt pin low 100 us, then self-clears.
// - Falling edge on external interrupt input sets its latch.
// - Status bit always mirrors external interrupt input level.
// - Watchdog input ignored in off modes and before reset release.
// - Watchdog edge is falling when invert is 0, rising when 1.
// - Selected watchdog edge is debounced 10 us before acting.
// - Hard watchdog reset when mode bit is 1, soft when 0.
// - In standby, watchdog acts only when standby-activity bit is 1.
// - Early warning high for selected lead time before fault power down.
// - Early warning triggered by four listed faults.
// - Early warning low in all off modes.
// - Early warning also high when input supply crosses warning threshold.
// - GP mode: pin follows run bit in run, standby bit in standby.
// - GP bits load 1 at power up when pin is in sequence, else 0.
// - PG mode: pin is AND of good signals of selected enabled regulators.
// - PG held low until reset release due; then good check or fault.
// - Aux regulator target from select pin, run or standby code.
// - Reset release slot field sets the power up slot at which reset is released.
package pin_ctrl_pkg;
   // ==========================================
   // Register map (byte addresses)
   localparam logic [7:0] CTRL_ADDR = 8'h00;
   localparam logic [7:0] SLOT_ADDR = 8'h04;
   localparam logic [7:0] VOLT_ADDR = 8'h08;
   localparam logic [7:0] IRQ_ADDR = 8'h0c;
   localparam logic [7:0] MASK_ADDR = 8'h10;
   localparam logic [7:0] STAT_ADDR = 8'h14;
   // ==========================================
   // Field positions
   localparam int CTRL_STBY_INV = 0;
   localparam int CTRL_WD_STBY = 1;
   localparam int CTRL_VSEL_EN = 2;
   localparam int CTRL_TEST = 3;
   localparam int CTRL_RUN_GP = 4;
   localparam int CTRL_STBY_GP = 5;
   localparam int CTRL_OVLO_EN = 6;
   localparam int CTRL_EWT = 8;
   localparam int IRQ_XINT = 0;
   localparam int IRQ_EW = 1;
   localparam int IRQ_W = 2;
   localparam int VOLT_STBY = 4;
   localparam int VOLT_SEL = 8;
   // ==========================================
   // Reset values and aux regulator codes
   localparam logic [7:0] SLOT_RST = 8'h01;
   localparam logic [3:0] AUX_CODE_3V3 = 4'hf;
   localparam logic [3:0] AUX_CODE_1V8 = 4'h8;
   localparam logic [3:0] AUX_RUN_RST = 4'h0;
   localparam logic [3:0] SYNC_IDLE = 4'h2;
   // ==========================================
   // Timing
   localparam int CLK_MHZ = 20;
   localparam int TEST_US = 100;
   localparam int DBNC_US = 10;
   localparam int EW0_US = 100;
   localparam int EW1_US = 5000;
   localparam int EW2_US = 20000;
   localparam int EW3_US = 50000;
   localparam int TEST_CYC = TEST_US * CLK_MHZ;
   localparam int DBNC_CYC = DBNC_US * CLK_MHZ;
   localparam int EW0_CYC = EW0_US * CLK_MHZ;
   localparam int EW1_CYC = EW1_US * CLK_MHZ;
   localparam int EW2_CYC = EW2_US * CLK_MHZ;
   localparam int EW3_CYC = EW3_US * CLK_MHZ;
   localparam int CNT_W = 20;
   typedef enum logic [0:0] {EW_IDLE, EW_LEAD} ew_state_type;
endpackage : pin_ctrl_pkg

// *** core/pin_ctrl.sv ***
// Control pin logic of the power chip, with an APB register slave.
// Assumes the power sequencer supplies state levels, slot count and
// fault events, all synchronous to pclk; open-drain pins drive low on oe.
`timescale 1ns/1ns
`default_nettype none
module pin_ctrl #(
   parameter int NREG = 8,
   parameter int EW_T1 = pin_ctrl_pkg::EW1_CYC,
   parameter int EW_T2 = pin_ctrl_pkg::EW2_CYC,
   parameter int EW_T3 = pin_ctrl_pkg::EW3_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic standby_in,
   input wire logic external_irq_in_n,
   input wire logic watchdog_in,
   input wire logic aux_voltage_select_in,
   input wire logic state_off,
   input wire logic state_pwrup,
   input wire logic state_run,
   input wire logic state_stby,
   input wire logic [7:0] seq_slot_now,
   input wire logic pd_reset_point,
   input wire logic fault_timer_exp,
   input wire logic regulator_fault_max,
   input wire logic thermal_sd,
   input wire logic input_overvolt,
   input wire logic vin_warn,
   input wire logic [NREG-1:0] reg_good,
   input wire logic [NREG-1:0] reg_enabled,
   input wire logic fuse_wd_invert,
   input wire logic fuse_wd_hard,
   input wire logic fuse_wd_stby,
   input wire logic fuse_pg_active,
   input wire logic fuse_gp_in_seq,
   input wire logic fuse_vsel_en,
   output logic standby_req,
   output logic processor_reset_out_oe,
   output logic interrupt_out_n_oe,
   output logic power_good_pin_oe,
   output logic power_good_fault,
   output logic early_warning_out,
   output logic early_warning_done,
   output logic wd_hard_reset,
   output logic wd_soft_reset,
   output logic [3:0] aux_target_code
);
   // ==========================================
   // Pin synchronisers
   logic [3:0] pin_raw;
   wire logic [3:0] sync_q;
   assign pin_raw = {aux_voltage_select_in, watchdog_in, external_irq_in_n, standby_in};
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_sync
         logic meta_q;
         logic stage_q;
         // two-stage sync
         // Reset to fixed levels (external interrupt high, the other three low) so no false edge follows reset
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               meta_q <= pin_ctrl_pkg::SYNC_IDLE[gi];
               stage_q <= pin_ctrl_pkg::SYNC_IDLE[gi];
            end else begin
               meta_q <= pin_raw[gi];
               stage_q <= meta_q;
            end
         end
         assign sync_q[gi] = stage_q;
      end
   endgenerate
   wire s_stby = sync_q[0];
   wire s_xint = sync_q[1];
   wire s_wdi = sync_q[2];
   wire s_vsel = sync_q[3];

   // ==========================================
   // Register file
   logic [9:0] ctrl_q;
   logic [7:0] slot_q;
   logic [7:0] run_code_q;
   logic [NREG-1:0] sel_q;
   localparam int CNT_W = pin_ctrl_pkg::CNT_W;
   logic [pin_ctrl_pkg::IRQ_W-1:0] irq_q, irq_d, mask_q;
   // Two latch sources drive separate bits, so this is a net
   wire logic [pin_ctrl_pkg::IRQ_W-1:0] irq_set;
   logic loaded_q;
   logic xint_prev_q;
   logic [CNT_W-1:0] test_cnt_q;
   logic [31:0] rdata_d;
   logic hit_d;
   logic test_done;
   logic rst_oe_q;
   wire wr = psel & penable & pwrite & pready;
   wire wr_ctrl = wr && paddr == pin_ctrl_pkg::CTRL_ADDR;
   wire wr_irq = wr && paddr == pin_ctrl_pkg::IRQ_ADDR;
   wire [pin_ctrl_pkg::IRQ_W-1:0] irq_clr = wr_irq ? pwdata[pin_ctrl_pkg::IRQ_W-1:0] : '0;

   always_comb begin
      hit_d = 1'b1;
      rdata_d = 32'h0;
      case (paddr)
         pin_ctrl_pkg::CTRL_ADDR: rdata_d[9:0] = ctrl_q;
         pin_ctrl_pkg::SLOT_ADDR: rdata_d[7:0] = slot_q;
         pin_ctrl_pkg::VOLT_ADDR: rdata_d[8+NREG-1:0] = {sel_q, run_code_q};
         pin_ctrl_pkg::IRQ_ADDR: rdata_d[pin_ctrl_pkg::IRQ_W-1:0] = irq_q;
         pin_ctrl_pkg::MASK_ADDR: rdata_d[pin_ctrl_pkg::IRQ_W-1:0] = mask_q;
         pin_ctrl_pkg::STAT_ADDR: rdata_d[4:0] = {early_warning_out, standby_req,
            ~rst_oe_q, s_vsel, s_xint};
         default: hit_d = 1'b0;
      endcase
   end

   // Answer in the access cycle right after setup: zero wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= psel & ~penable & ~hit_d;
         prdata <= (psel & ~penable & ~pwrite) ? rdata_d : 32'h0;
      end
   end

   // Straps are caught on the first edge after reset release
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q <= '0;
         loaded_q <= 1'b0;
      end else if (!loaded_q) begin
         loaded_q <= 1'b1;
         ctrl_q[pin_ctrl_pkg::CTRL_WD_STBY] <= fuse_wd_stby;
         ctrl_q[pin_ctrl_pkg::CTRL_VSEL_EN] <= fuse_vsel_en;
         ctrl_q[pin_ctrl_pkg::CTRL_RUN_GP] <= fuse_gp_in_seq;
         ctrl_q[pin_ctrl_pkg::CTRL_STBY_GP] <= fuse_gp_in_seq;
      end else if (wr_ctrl) begin
         ctrl_q <= pwdata[9:0];
      end else if (test_done) begin
         ctrl_q[pin_ctrl_pkg::CTRL_TEST] <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         slot_q <= pin_ctrl_pkg::SLOT_RST;
         run_code_q <= {pin_ctrl_pkg::AUX_RUN_RST, pin_ctrl_pkg::AUX_RUN_RST};
         sel_q <= '0;
         mask_q <= '0;
      end else if (wr) begin
         if (paddr == pin_ctrl_pkg::SLOT_ADDR) slot_q <= pwdata[7:0];
         if (paddr == pin_ctrl_pkg::VOLT_ADDR) begin
            run_code_q <= pwdata[7:0];
            sel_q <= pwdata[8+NREG-1:8];
         end
         if (paddr == pin_ctrl_pkg::MASK_ADDR) mask_q <= pwdata[pin_ctrl_pkg::IRQ_W-1:0];
      end
   end

   // ==========================================
   // Interrupt latches and pin
   // falling edge of external input
   assign irq_set[pin_ctrl_pkg::IRQ_XINT] = xint_prev_q & ~s_xint;
   // write-one clear; a same-cycle set wins
   assign irq_d = (irq_q & ~irq_clr) | irq_set;
   wire test_active = test_cnt_q != '0;
   assign test_done = test_cnt_q == CNT_W'(1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= '0;
         xint_prev_q <= 1'b1;
         test_cnt_q <= '0;
         interrupt_out_n_oe <= 1'b0;
      end else begin
         irq_q <= irq_d;
         xint_prev_q <= s_xint;
         if (wr_ctrl && pwdata[pin_ctrl_pkg::CTRL_TEST] && !test_active)
            test_cnt_q <= CNT_W'(pin_ctrl_pkg::TEST_CYC);
         else if (test_active)
            test_cnt_q <= test_cnt_q - CNT_W'(1);
         interrupt_out_n_oe <= (|(irq_q & ~mask_q)) | test_active;
      end
   end

   // ==========================================
   // Standby request and processor reset
   wire sys_on = state_run | state_stby;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         standby_req <= 1'b0;
         rst_oe_q <= 1'b1;
      end else begin
         standby_req <= s_stby ^ ctrl_q[pin_ctrl_pkg::CTRL_STBY_INV];
         // reset point or off wins over release
         if (pd_reset_point || state_off)
            rst_oe_q <= 1'b1;
         else if (state_pwrup && seq_slot_now == slot_q)
            rst_oe_q <= 1'b0;
      end
   end
   assign processor_reset_out_oe = rst_oe_q;

   // ==========================================
   // Watchdog input
   logic [7:0] dbnc_q;
   logic wd_stable_q;
   // asserted level chosen by edge invert strap
   wire wd_level = fuse_wd_invert ? s_wdi : ~s_wdi;
   wire wd_enable = ~rst_oe_q & (state_run |
      (state_stby & ctrl_q[pin_ctrl_pkg::CTRL_WD_STBY]));
   wire wd_qual = wd_level != wd_stable_q && dbnc_q == 8'(pin_ctrl_pkg::DBNC_CYC - 1);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dbnc_q <= '0;
         wd_stable_q <= 1'b0;
         wd_hard_reset <= 1'b0;
         wd_soft_reset <= 1'b0;
      end else begin
         // level must hold the full debounce time
         if (wd_level == wd_stable_q) dbnc_q <= '0;
         else if (wd_qual) dbnc_q <= '0;
         else dbnc_q <= dbnc_q + 8'(1);
         if (wd_qual) wd_stable_q <= wd_level;
         // hard or soft by mode strap
         wd_hard_reset <= wd_qual & wd_level & wd_enable & fuse_wd_hard;
         wd_soft_reset <= wd_qual & wd_level & wd_enable & ~fuse_wd_hard;
      end
   end

   // ==========================================
   // Early warning
   pin_ctrl_pkg::ew_state_type ew_q;
   logic [CNT_W-1:0] ew_cnt_q;
   logic [CNT_W-1:0] ew_len;
   wire ew_fault = fault_timer_exp | regulator_fault_max | thermal_sd |
      (input_overvolt & ctrl_q[pin_ctrl_pkg::CTRL_OVLO_EN]);
   wire ew_start = ew_fault && ew_q == pin_ctrl_pkg::EW_IDLE && !state_off;
   assign irq_set[pin_ctrl_pkg::IRQ_EW] = ew_start;
   always_comb begin
      case (ctrl_q[pin_ctrl_pkg::CTRL_EWT +: 2])
         2'b00: ew_len = CNT_W'(pin_ctrl_pkg::EW0_CYC);
         2'b01: ew_len = CNT_W'(EW_T1);
         2'b10: ew_len = CNT_W'(EW_T2);
         default: ew_len = CNT_W'(EW_T3);
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ew_q <= pin_ctrl_pkg::EW_IDLE;
         ew_cnt_q <= '0;
         early_warning_out <= 1'b0;
         early_warning_done <= 1'b0;
      end else begin
         early_warning_done <= 1'b0;
         case (ew_q)
            pin_ctrl_pkg::EW_IDLE: if (ew_start) begin
               ew_q <= pin_ctrl_pkg::EW_LEAD;
               ew_cnt_q <= ew_len - CNT_W'(1);
            end
            pin_ctrl_pkg::EW_LEAD: begin
               // power down may start once the lead time is over
               if (ew_cnt_q == '0) begin
                  ew_q <= pin_ctrl_pkg::EW_IDLE;
                  early_warning_done <= 1'b1;
               end else begin
                  ew_cnt_q <= ew_cnt_q - CNT_W'(1);
               end
            end
            default: ew_q <= pin_ctrl_pkg::EW_IDLE;
         endcase
         // low when off, else lead window or supply warning
         early_warning_out <= ~state_off & (ew_start | (ew_q == pin_ctrl_pkg::EW_LEAD &&
            ew_cnt_q != '0) | vin_warn);
      end
   end

   // ==========================================
   // Power good pin and aux regulator target
   // disabled or unselected regulators count as good
   wire pg_all_good = &(reg_good | ~(sel_q & reg_enabled));
   wire rel_due = state_pwrup && seq_slot_now == slot_q && rst_oe_q;
   // Once reset is released the pin stays unmasked for the rest of power up
   wire pg_unmask = ~state_off & (sys_on | rel_due | ~rst_oe_q);
   logic gp_level;
   assign gp_level = (state_run & ctrl_q[pin_ctrl_pkg::CTRL_RUN_GP]) |
      (state_stby & ctrl_q[pin_ctrl_pkg::CTRL_STBY_GP]);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_good_pin_oe <= 1'b1;
         power_good_fault <= 1'b0;
         aux_target_code <= pin_ctrl_pkg::AUX_RUN_RST;
      end else begin
         // held low until release is due
         if (fuse_pg_active)
            power_good_pin_oe <= ~(pg_unmask & pg_all_good);
         else
            power_good_pin_oe <= ~gp_level;
         power_good_fault <= fuse_pg_active & rel_due & ~pg_all_good;
         // standby code wins, then pin select, then run code
         if (state_stby)
            aux_target_code <= run_code_q[pin_ctrl_pkg::VOLT_STBY +: 4];
         else if (ctrl_q[pin_ctrl_pkg::CTRL_VSEL_EN])
            aux_target_code <= s_vsel ? pin_ctrl_pkg::AUX_CODE_1V8 : pin_ctrl_pkg::AUX_CODE_3V3;
         else
            aux_target_code <= run_code_q[3:0];
      end
   end

   // ==========================================
   // Assertions
   sequence s_xint_fall;
      xint_prev_q && !s_xint;
   endsequence
   sequence s_test_start;
      wr_ctrl && pwdata[pin_ctrl_pkg::CTRL_TEST] && !test_active;
   endsequence
   AST_STBY_POL: assert property (@(posedge pclk) disable iff (!presetn)
      ##1 standby_req == $past(s_stby ^ ctrl_q[pin_ctrl_pkg::CTRL_STBY_INV]))
      else $error("standby request wrong");
   AST_RST_REL: assert property (@(posedge pclk) disable iff (!presetn)
      (state_pwrup && !state_off && !pd_reset_point && seq_slot_now == slot_q)
      |=> !processor_reset_out_oe) else $error("reset not released at slot");
   AST_RST_PD: assert property (@(posedge pclk) disable iff (!presetn)
      pd_reset_point |=> processor_reset_out_oe) else $error("reset not asserted");
   AST_INT_PEND: assert property (@(posedge pclk) disable iff (!presetn)
      (|(irq_q & ~mask_q)) |=> interrupt_out_n_oe) else $error("interrupt pin idle");
   AST_TEST_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
      s_test_start |=> ##1 interrupt_out_n_oe [*8]) else $error("test pulse short");
   AST_XINT_SET: assert property (@(posedge pclk) disable iff (!presetn)
      s_xint_fall |=> irq_q[pin_ctrl_pkg::IRQ_XINT]) else $error("external latch missed");
   AST_WD_MASK: assert property (@(posedge pclk) disable iff (!presetn)
      !wd_enable |=> !wd_hard_reset && !wd_soft_reset) else $error("watchdog not masked");
   AST_EW_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      state_off |=> !early_warning_out) else $error("early warning in off mode");
   AST_EW_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      ew_start |=> irq_q[pin_ctrl_pkg::IRQ_EW] && early_warning_out)
      else $error("early warning start missed");
   AST_AUX_STBY: assert property (@(posedge pclk) disable iff (!presetn)
      state_stby |=> aux_target_code == $past(run_code_q[7:4]))
      else $error("standby aux code wrong");
   AST_RST_OFF: assert property (@(posedge pclk) disable iff (!presetn)
      state_off |=> processor_reset_out_oe) else $error("reset not held in off");
   AST_PG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      fuse_pg_active && (state_off || (state_pwrup && rst_oe_q && !rel_due))
      |=> power_good_pin_oe) else $error("power good released early");
   AST_PG_GPO: assert property (@(posedge pclk) disable iff (!presetn)
      !fuse_pg_active && state_run
      |=> power_good_pin_oe == !$past(ctrl_q[pin_ctrl_pkg::CTRL_RUN_GP]))
      else $error("general purpose level wrong");
   AST_EW_VIN: assert property (@(posedge pclk) disable iff (!presetn)
      vin_warn && !state_off |=> early_warning_out) else $error("supply warning missed");
   AST_IRQ_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      wr_irq && pwdata[pin_ctrl_pkg::IRQ_XINT] && !irq_set[pin_ctrl_pkg::IRQ_XINT]
      |=> !irq_q[pin_ctrl_pkg::IRQ_XINT]) else $error("latch not cleared");
   AST_AUX_PIN: assert property (@(posedge pclk) disable iff (!presetn)
      !state_stby && ctrl_q[pin_ctrl_pkg::CTRL_VSEL_EN] |=> aux_target_code ==
      ($past(s_vsel) ? pin_ctrl_pkg::AUX_CODE_1V8 : pin_ctrl_pkg::AUX_CODE_3V3))
      else $error("aux pin select wrong");
endmodule : pin_ctrl
`default_nettype wire

// *** sim/host_model.sv ***
// Host processor and companion power chip, as seen at the control pins.
// Assumes the bench commands each pulse; every change follows a rising pclk.
`timescale 1ns/1ns
`default_nettype none
module host_model (
   input wire logic pclk,
   input wire logic wd_invert,
   input wire logic [15:0] wd_hold,
   input wire logic wd_go,
   input wire logic irq_low,
   output logic watchdog_in,
   output logic external_irq_in_n
);
   int left = 0;
   // ==========================================
   // Watchdog pulse
   // hold asserted level
   always @(posedge pclk) begin
      if (wd_go) begin
         left <= int'(wd_hold);
      end else if (left > 0) begin
         left <= left - 1;
      end
   end
   // idle level opposes the asserting edge
   assign watchdog_in = (left > 0) ? wd_invert : !wd_invert;
   // Pull-up keeps the line high when the companion lets go
   assign external_irq_in_n = !irq_low;
endmodule : host_model
`default_nettype wire

// *** sim/tb_pmic_control_pin_logic.sv ***
// Self-checking bench for the control pin logic over APB.
// Assumes zero-wait APB and the sim lead times set by the parameters below.
`timescale 1ns/1ns
`default_nettype none
module tb_pmic_control_pin_logic;
   localparam int T1 = 40;
   localparam int T2 = 60;
   localparam int T3 = 80;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] rd;
   logic er;
   logic standby_in = 0, aux_sel = 0, pd_pt = 0, vin_warn = 0, wd_go = 0, irq_low = 0;
   logic [3:0] st = 4'h1;
   logic [3:0] flt = 4'h0;
   logic [7:0] slot_now = 8'h00;
   logic [7:0] good = 8'hff;
   logic [7:0] ena = 8'hff;
   logic [15:0] wd_hold = 16'h0;
   logic f_inv = 0, f_hard = 0, f_stby = 0, f_pg = 1, f_gp = 0, f_vsel = 0;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, stby_req, rst_oe, irq_oe, pg_oe, ew, wd_h, wd_s, wd_pin, xirq;
   wire logic [3:0] aux;
   int fail_count = 0;
   int tests_run = 0;
   int lead[4] = '{pin_ctrl_pkg::EW0_CYC, T1, T2, T3};
   logic [31:0] ctrl;
   logic [3:0] vr, vs;
   logic pin, inv;
   int n;

   always #25 pclk = ~pclk;

   pin_ctrl #(.NREG(8), .EW_T1(T1), .EW_T2(T2), .EW_T3(T3)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .standby_in(standby_in), .external_irq_in_n(xirq), .watchdog_in(wd_pin),
      .aux_voltage_select_in(aux_sel), .state_off(st[0]), .state_pwrup(st[1]),
      .state_run(st[2]), .state_stby(st[3]), .seq_slot_now(slot_now), .pd_reset_point(pd_pt),
      .fault_timer_exp(flt[0]), .regulator_fault_max(flt[1]), .thermal_sd(flt[2]),
      .input_overvolt(flt[3]), .vin_warn(vin_warn), .reg_good(good), .reg_enabled(ena),
      .fuse_wd_invert(f_inv), .fuse_wd_hard(f_hard), .fuse_wd_stby(f_stby),
      .fuse_pg_active(f_pg), .fuse_gp_in_seq(f_gp), .fuse_vsel_en(f_vsel),
      .standby_req(stby_req), .processor_reset_out_oe(rst_oe), .interrupt_out_n_oe(irq_oe),
      .power_good_pin_oe(pg_oe), .power_good_fault(), .early_warning_out(ew),
      .early_warning_done(), .wd_hard_reset(wd_h), .wd_soft_reset(wd_s), .aux_target_code(aux));

   host_model host (.pclk(pclk), .wd_invert(f_inv), .wd_hold(wd_hold), .wd_go(wd_go),
      .irq_low(irq_low), .watchdog_in(wd_pin), .external_irq_in_n(xirq));

   // ==========================================
   // Shared tasks
   task finish_test;
      $display("Checks made %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task cyc(input int c);
      repeat (c) @(negedge pclk);
   endtask : cyc

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 16);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
      if (pready !== 1'b1) begin
         fail_count++;
         finish_test();
      end
   endtask : apb

   task wd_try(input int hold, input logic eh, input logic es);
      logic h, s;
      h = 0;
      s = 0;
      @(posedge pclk);
      wd_hold <= 16'(hold);
      wd_go <= 1;
      @(posedge pclk);
      wd_go <= 0;
      repeat (hold + pin_ctrl_pkg::DBNC_CYC + 60) begin
         @(negedge pclk);
         h = h | wd_h;
         s = s | wd_s;
      end
      chk("wd_hard", h, eh);
      chk("wd_soft", s, es);
   endtask : wd_try

   // ==========================================
   // Main sequence
   initial begin
      void'($urandom(43));
      repeat (4) @(posedge pclk);
      presetn <= 1;
      cyc(3);
      apb(0, pin_ctrl_pkg::SLOT_ADDR, 0);
      chk("slot_reset", rd, {24'h0, pin_ctrl_pkg::SLOT_RST});
      apb(0, 8'h18, 0);
      chk("unmapped_err", er, 1);
      chk("unmapped_rd", rd, 0);
      for (int i = 0; i < 8; i++) begin
         inv = 1'($urandom % 2);
         pin = 1'($urandom % 2);
         apb(1, pin_ctrl_pkg::CTRL_ADDR, {31'h0, inv});
         standby_in <= pin;
         cyc(5);
         chk("standby_req", stby_req, pin ^ inv);
      end
      $display("regs and standby done");
      @(posedge pclk);
      st <= 4'h2;
      apb(1, pin_ctrl_pkg::SLOT_ADDR, 32'h5);
      slot_now <= 8'h04;
      cyc(5);
      chk("rst_early", rst_oe, 1);
      chk("pg_early", pg_oe, 1);
      @(posedge pclk);
      slot_now <= 8'h05;
      cyc(5);
      chk("rst_slot", rst_oe, 0);
      chk("pg_slot", pg_oe, 0);
      @(posedge pclk);
      st <= 4'h4;
      cyc(4);
      chk("rst_run", rst_oe, 0);
      apb(1, pin_ctrl_pkg::VOLT_ADDR, 32'hff00);
      good <= 8'hf7;
      cyc(4);
      chk("pg_bad", pg_oe, 1);
      @(posedge pclk);
      ena <= 8'hf7;
      cyc(4);
      chk("pg_disabled", pg_oe, 0);
      @(posedge pclk);
      good <= 8'hff;
      ena <= 8'hff;
      f_pg <= 0;
      cyc(4);
      chk("gp_run_level", pg_oe, 1);
      @(posedge pclk);
      f_pg <= 1;
      $display("power up and good done");
      vr = 4'($urandom);
      vs = 4'($urandom);
      apb(1, pin_ctrl_pkg::VOLT_ADDR, {16'h0, 8'hff, vs, vr});
      apb(1, pin_ctrl_pkg::CTRL_ADDR, 32'h4);
      cyc(4);
      chk("aux_low", aux, pin_ctrl_pkg::AUX_CODE_3V3);
      @(posedge pclk);
      aux_sel <= 1;
      cyc(4);
      chk("aux_high", aux, pin_ctrl_pkg::AUX_CODE_1V8);
      apb(0, pin_ctrl_pkg::STAT_ADDR, 0);
      chk("aux_level", rd[1], 1);
      apb(1, pin_ctrl_pkg::CTRL_ADDR, 32'h0);
      cyc(4);
      chk("aux_run", aux, vr);
      @(posedge pclk);
      st <= 4'h8;
      cyc(4);
      chk("aux_stby", aux, vs);
      @(posedge pclk);
      st <= 4'h4;
      irq_low <= 1;
      cyc(6);
      chk("xirq_pin_low", irq_oe, 1);
      apb(1, pin_ctrl_pkg::MASK_ADDR, 32'h1);
      apb(0, pin_ctrl_pkg::STAT_ADDR, 0);
      chk("xirq_level_low", rd[0], 0);
      chk("xirq_masked", irq_oe, 0);
      irq_low <= 0;
      cyc(6);
      apb(0, pin_ctrl_pkg::STAT_ADDR, 0);
      chk("xirq_level_high", rd[0], 1);
      apb(1, pin_ctrl_pkg::MASK_ADDR, 32'h0);
      cyc(2);
      chk("xirq_unmasked", irq_oe, 1);
      apb(1, pin_ctrl_pkg::IRQ_ADDR, 32'h1);
      apb(0, pin_ctrl_pkg::IRQ_ADDR, 0);
      chk("xirq_cleared", rd[0], 0);
      chk("irq_released", irq_oe, 0);
      apb(1, pin_ctrl_pkg::CTRL_ADDR, 32'h8);
      n = 0;
      while (irq_oe !== 1'b1 && n < 10) begin
         @(negedge pclk);
         n++;
      end
      n = 0;
      while (irq_oe === 1'b1 && n < 3000) begin
         @(negedge pclk);
         n++;
      end
      chk("test_len", (n >= pin_ctrl_pkg::TEST_CYC - 3) &&
         (n <= pin_ctrl_pkg::TEST_CYC + 3), 1);
      apb(0, pin_ctrl_pkg::CTRL_ADDR, 0);
      chk("test_selfclear", rd[3], 0);
      $display("aux and interrupt done");
      for (int i = 0; i < 4; i++) begin
         ctrl = (i << 8) | 32'h40;
         apb(1, pin_ctrl_pkg::CTRL_ADDR, ctrl);
         flt <= 4'(1 << i);
         @(posedge pclk);
         flt <= 4'h0;
         cyc(1);
         n = 0;
         while (ew === 1'b1 && n < 3000) begin
            @(negedge pclk);
            n++;
         end
         chk("ew_len", (n >= lead[i] - 2) && (n <= lead[i] + 1), 1);
         apb(0, pin_ctrl_pkg::IRQ_ADDR, 0);
         chk("ew_irq", rd[1], 1);
         apb(1, pin_ctrl_pkg::IRQ_ADDR, 32'h2);
      end
      apb(1, pin_ctrl_pkg::CTRL_ADDR, 32'h0);
      flt <= 4'h8;
      @(posedge pclk);
      flt <= 4'h0;
      cyc(5);
      chk("ew_ovlo_off", ew, 0);
      @(posedge pclk);
      vin_warn <= 1;
      cyc(4);
      chk("ew_vin", ew, 1);
      @(posedge pclk);
      vin_warn <= 0;
      apb(1, pin_ctrl_pkg::IRQ_ADDR, 32'h3);
      $display("early warning done");
      f_hard <= 1;
      wd_try(260, 1, 0);
      @(posedge pclk);
      f_hard <= 0;
      wd_try(260, 0, 1);
      wd_try(100, 0, 0);
      @(posedge pclk);
      st <= 4'h8;
      wd_try(260, 0, 0);
      apb(1, pin_ctrl_pkg::CTRL_ADDR, 32'h2);
      wd_try(260, 0, 1);
      @(posedge pclk);
      st <= 4'h4;
      f_inv <= 1;
      cyc(10);
      wd_try(260, 0, 1);
      @(posedge pclk);
      pd_pt <= 1;
      @(posedge pclk);
      pd_pt <= 0;
      cyc(4);
      chk("rst_pd", rst_oe, 1);
      @(posedge pclk);
      st <= 4'h1;
      flt <= 4'h1;
      @(posedge pclk);
      flt <= 4'h0;
      cyc(5);
      chk("ew_off", ew, 0);
      wd_try(260, 0, 0);
      $display("watchdog and off done");
      finish_test();
   end
endmodule : tb_pmic_control_pin_logic
`default_nettype wire
